// ===== rtl/pgc_params.svh
// Constants for the two-pin GPIO configuration block.
// Assumes a 40 MHz clock and an Avalon-MM register slave.
// How it works
// - Sleep-force-low drives output low in sleep
// - Input debounce selectable, 94 or 156 us
// - Direction bit clear makes pad input
// - Direction set: output and seq_owned_o high; sequencer value drives pin only when the sequencer-select bit is set
// - Read-only bit reports pad level
// - Power-on reset loads OTP defaults
// - Output drives value bit level; with open-drain set, a value bit of one releases the pad
`ifndef PGC_PARAMS_SVH
`define PGC_PARAMS_SVH

// ----------------------------------------
// Register map (register index, byte address is four times it)
// ----------------------------------------
`define PGC_IDX_PIN3        8'h43
`define PGC_IDX_PIN4        8'h44
`define PGC_IDX_CTRL        8'h50

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PGC_B_VALUE         0
`define PGC_B_LEVEL         1
`define PGC_B_DIR           2
`define PGC_B_PULLDOWN      3
`define PGC_B_DEBOUNCE      4
`define PGC_B_OPEN_DRAIN    5
`define PGC_B_SEQ_SEL       6
`define PGC_B_SLEEP_LOW     7
`define PGC_WR_MASK         8'hFD

// ----------------------------------------
// Timing
// ----------------------------------------
`define PGC_CLK_MHZ         40
`define PGC_DEB_SHORT_US    94
`define PGC_DEB_LONG_US     156
`define PGC_DEB_SHORT_CYC   (`PGC_DEB_SHORT_US * `PGC_CLK_MHZ)
`define PGC_DEB_LONG_CYC    (`PGC_DEB_LONG_US * `PGC_CLK_MHZ)

`endif

// ===== rtl/pgc_pkg.sv
// Types for the GPIO configuration block.
// Assumes nothing beyond the params header.
package pgc_pkg;
	typedef enum logic [1:0] {
		PGC_IDLE = 2'b00,
		PGC_ANS  = 2'b01
	} pgc_bus_type;
endpackage

// ===== rtl/pgc_debounce.sv
// Debounce filter for one pad input.
// Assumes the input is already synchronised to clk_i.
`timescale 1ns/1ps
`include "pgc_params.svh"
module pgc_debounce (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic nrst_i,
	// Control
	input  wire logic long_i,
	input  wire logic raw_i,
	// Filtered level
	output logic      level_o
);
	logic [12:0] cnt_r;
	logic        level_r;
	wire  [12:0] limit = long_i ? 13'(`PGC_DEB_LONG_CYC - 1) : 13'(`PGC_DEB_SHORT_CYC - 1);
	wire         differ = raw_i != level_r;
	wire         done = differ && (cnt_r >= limit);

	// ----------------------------------------
	// Count stable cycles of a changed input
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r   <= 13'h0000;
			level_r <= 1'b0;
		end else if (!differ || done) begin
			cnt_r   <= 13'h0000;
			level_r <= done ? raw_i : level_r;
		end else begin
			cnt_r <= cnt_r + 13'h0001;
		end
	end
	assign level_o = level_r;

	chk_debounce_wait: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$changed(level_r) |-> $past(differ, 1) && ($past(cnt_r, 1) >= ($past(long_i, 1)
			? 13'(`PGC_DEB_LONG_CYC - 1) : 13'(`PGC_DEB_SHORT_CYC - 1))))
		else $error("debounce level changed too early");
endmodule

// ===== rtl/pgc_pin.sv
// Pad driver and input path for one configurable pin.
// Assumes the pad wire is resolved outside from oe and out.
`timescale 1ns/1ps
`include "pgc_params.svh"
module pgc_pin (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Configuration and state
	input  wire logic [7:0] cfg_i,
	input  wire logic       sleep_i,
	input  wire logic       seq_val_i,
	// Pad
	input  wire logic       pad_i,
	output logic            pad_o,
	output logic            pad_oe_o,
	output logic            pulldown_o,
	// Filtered level
	output logic            level_o
);
	logic [2:0] sync_r;
	logic       clean_r;
	logic       out_r;
	logic       oe_r;
	wire        is_out = cfg_i[`PGC_B_DIR];
	wire        force_low = cfg_i[`PGC_B_SLEEP_LOW] && is_out && sleep_i;
	wire        src_val = cfg_i[`PGC_B_SEQ_SEL] ? seq_val_i : cfg_i[`PGC_B_VALUE];
	wire        val_nxt = force_low ? 1'b0 : src_val;
	wire        oe_nxt = is_out && !(cfg_i[`PGC_B_OPEN_DRAIN] && val_nxt);

	// ----------------------------------------
	// Input synchroniser and output flops
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sync_r  <= 3'h0;
			clean_r <= 1'b0;
			out_r   <= 1'b0;
			oe_r    <= 1'b0;
		end else begin
			sync_r  <= {sync_r[1:0], pad_i};
			clean_r <= (sync_r[1] == sync_r[2]) ? sync_r[2] : clean_r;
			out_r   <= val_nxt;
			oe_r    <= oe_nxt;
		end
	end
	assign pad_o      = out_r;
	assign pad_oe_o   = oe_r;
	assign pulldown_o = cfg_i[`PGC_B_PULLDOWN] && !is_out;

	pgc_debounce u_deb (
		.clk_i   (clk_i),
		.nrst_i  (nrst_i),
		.long_i  (cfg_i[`PGC_B_DEBOUNCE]),
		.raw_i   (clean_r),
		.level_o (level_o)
	);

	chk_sleep_low: assert property (@(posedge clk_i) disable iff (!nrst_i)
		force_low |=> !pad_o) else $error("sleep did not force low");
	chk_input_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!is_out |=> !pad_oe_o) else $error("input pad driven");
	chk_out_value: assert property (@(posedge clk_i) disable iff (!nrst_i)
		is_out && !sleep_i && !cfg_i[`PGC_B_SEQ_SEL] |=> pad_o == $past(cfg_i[`PGC_B_VALUE]))
		else $error("output value wrong");
endmodule

// ===== rtl/pgc_top.sv
// Register slave and two configurable pins.
// Assumes an Avalon-MM master and OTP defaults stable during reset release.
//
// The Avalon-MM register port was chosen for this implementation.
`timescale 1ns/1ps
`include "pgc_params.svh"
module pgc_top (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	// Avalon-MM slave
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	output logic [1:0]       avs_response,
	// OTP defaults and system state
	input  wire logic [7:0]  otp_pin3_i,
	input  wire logic [7:0]  otp_pin4_i,
	input  wire logic        sleep_i,
	input  wire logic [1:0]  seq_val_i,
	// Pads
	input  wire logic [1:0]  pad_i,
	output logic [1:0]       pad_o,
	output logic [1:0]       pad_oe_o,
	output logic [1:0]       pulldown_o,
	output logic [1:0]       seq_owned_o
);
	pgc_pkg::pgc_bus_type st_r;
	logic [7:0]  cfg_r [2];
	logic        loaded_r;
	logic [31:0] rdata_r;
	logic [1:0]  resp_r;
	wire  [1:0]  level;
	wire  [7:0]  idx = avs_address[9:2];
	wire         hit3 = idx == `PGC_IDX_PIN3;
	wire         hit4 = idx == `PGC_IDX_PIN4;
	wire         hit_c = idx == `PGC_IDX_CTRL;
	wire         hit = (hit3 || hit4 || hit_c) && avs_address[1:0] == 2'b00;
	wire         req = avs_read || avs_write;
	wire         take = st_r == pgc_pkg::PGC_IDLE && req;
	wire         ans = st_r == pgc_pkg::PGC_ANS;
	wire         wr_ok = ans && avs_write && hit && avs_byteenable[0] && loaded_r;
	wire  [7:0]  rd3 = {cfg_r[0][7:2], level[0], cfg_r[0][0]};
	wire  [7:0]  rd4 = {cfg_r[1][7:2], level[1], cfg_r[1][0]};
	wire  [7:0]  rd_sel = hit3 ? rd3 : hit4 ? rd4 : {7'h00, loaded_r};

	// ----------------------------------------
	// Bus state: answer one cycle after taking
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r    <= pgc_pkg::PGC_IDLE;
			rdata_r <= 32'h0000_0000;
			resp_r  <= 2'b00;
		end else if (take) begin
			st_r    <= pgc_pkg::PGC_ANS;
			rdata_r <= (avs_read && hit) ? {24'h00_0000, rd_sel} : 32'h0000_0000;
			resp_r  <= hit ? 2'b00 : 2'b11;
		end else begin
			st_r <= pgc_pkg::PGC_IDLE;
		end
	end
	assign avs_waitrequest = !ans;
	assign avs_readdata    = rdata_r;
	assign avs_response    = resp_r;

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			loaded_r <= 1'b0;
			cfg_r[0] <= 8'h00;
			cfg_r[1] <= 8'h00;
		end else if (!loaded_r) begin
			loaded_r <= 1'b1;
			cfg_r[0] <= otp_pin3_i & `PGC_WR_MASK;
			cfg_r[1] <= otp_pin4_i & `PGC_WR_MASK;
		end else if (wr_ok && hit3) begin
			cfg_r[0] <= avs_writedata[7:0] & `PGC_WR_MASK;
		end else if (wr_ok && hit4) begin
			cfg_r[1] <= avs_writedata[7:0] & `PGC_WR_MASK;
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_pin
			pgc_pin u_pin (
				.clk_i      (clk_i),
				.nrst_i     (nrst_i),
				.cfg_i      (cfg_r[g]),
				.sleep_i    (sleep_i),
				.seq_val_i  (seq_val_i[g]),
				.pad_i      (pad_i[g]),
				.pad_o      (pad_o[g]),
				.pad_oe_o   (pad_oe_o[g]),
				.pulldown_o (pulldown_o[g]),
				.level_o    (level[g])
			);
			assign seq_owned_o[g] = cfg_r[g][`PGC_B_DIR];
		end
	endgenerate

	chk_bus_answer: assert property (@(posedge clk_i) disable iff (!nrst_i)
		take |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
	chk_level_ro: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!cfg_r[0][`PGC_B_LEVEL] && !cfg_r[1][`PGC_B_LEVEL]) else $error("status bit stored");
	chk_otp_load: assert property (@(posedge clk_i) disable iff (!nrst_i)
		$rose(loaded_r) |-> cfg_r[0] == ($past(otp_pin3_i) & `PGC_WR_MASK)
			&& cfg_r[1] == ($past(otp_pin4_i) & `PGC_WR_MASK)) else $error("otp load wrong");
	chk_seq_owned: assert property (@(posedge clk_i) disable iff (!nrst_i)
		cfg_r[0][`PGC_B_DIR] && !cfg_r[0][`PGC_B_OPEN_DRAIN] |-> seq_owned_o[0] ##1 pad_oe_o[0])
		else $error("output pin not driven");
	chk_level_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
		take && avs_read && hit3 |=> avs_readdata[`PGC_B_LEVEL] == $past(level[0]))
		else $error("pad level not read back");
	chk_input_mode: assert property (@(posedge clk_i) disable iff (!nrst_i)
		!cfg_r[1][`PGC_B_DIR] ##1 !cfg_r[1][`PGC_B_DIR] |-> !pad_oe_o[1]) else $error("input driven");
endmodule

// ===== rtl/pgc_unused_check.sv
// Reserved file of the pin block; it holds no logic.
// All checks sit beside the logic that they guard.

// ===== test/pgc_pad_model.sv
// Board side of the two pads: pull-up, optional external driver.
// Assumes the block's drive, enable and pull-down outputs as inputs.
`timescale 1ns/1ps
module pgc_pad_model (
	// From the block
	input  wire logic [1:0] drv_i,
	input  wire logic [1:0] oe_i,
	input  wire logic [1:0] pd_i,
	// External driver
	input  wire logic [1:0] ext_en_i,
	input  wire logic [1:0] ext_v_i,
	// Resolved level
	output logic      [1:0] pad_lvl_o
);
	// Block drive wins, then external driver, then pull-down over pull-up
	assign pad_lvl_o = (oe_i & drv_i) | (~oe_i & ext_en_i & ext_v_i)
		| (~oe_i & ~ext_en_i & ~pd_i);
endmodule

// ===== test/pgc_top_tb.sv
// Testbench for the GPIO pin configuration block.
// Assumes the pad model above and a 40 MHz clock.
`timescale 1ns/1ps
module pgc_top_tb;
	logic        clk_i, nrst_i, avs_read, avs_write, sleep_i;
	logic [9:0]  avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic [3:0]  avs_byteenable;
	logic        avs_waitrequest;
	logic [1:0]  avs_response, seq_val_i, pad_i, pad_o, pad_oe_o, pulldown_o, seq_owned_o;
	logic [1:0]  ext_en, ext_v, rsp;
	logic [7:0]  otp_pin3_i, otp_pin4_i, rd;
	logic [12:0] tbl [8];
	int          miscompares, total_checks, n, i;

	pgc_top pgc_top_i (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
		.otp_pin3_i(otp_pin3_i), .otp_pin4_i(otp_pin4_i), .sleep_i(sleep_i),
		.seq_val_i(seq_val_i), .pad_i(pad_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o),
		.pulldown_o(pulldown_o), .seq_owned_o(seq_owned_o));
	pgc_pad_model pgc_pad_model_i (.drv_i(pad_o), .oe_i(pad_oe_o), .pd_i(pulldown_o),
		.ext_en_i(ext_en), .ext_v_i(ext_v), .pad_lvl_o(pad_i));

	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon-MM transfer, held until waitrequest is sampled low
	task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_i);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= {24'h00_0000, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		if (n >= 100) begin
			miscompares++;
			$display("MISMATCH at %0t: bus timeout", $time);
		end
		rd = avs_readdata[7:0];
		rsp = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task conclude;
		$display("Checks: %0d, mismatches: %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (40000) @(posedge clk_i);
		miscompares++;
		$display("MISMATCH at %0t: watchdog expired", $time);
		conclude;
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		// Entry: sleep, config, expected {oe, drive, pull-down, sequencer}
		tbl = '{13'h005D, 13'h0049, 13'h1859, 13'h105D, 13'h044D, 13'h0251, 13'h0082, 13'h0000};
		{nrst_i, avs_read, avs_write, sleep_i, ext_v} = '0;
		{avs_address, avs_writedata} = '0;
		avs_byteenable = 4'hF;
		otp_pin3_i = 8'h08;
		otp_pin4_i = 8'h00;
		seq_val_i = 2'b01;
		ext_en = 2'b10;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		bus(1'b0, 10'h10C, 8'h00);
		chk(rd & 8'hFD, 8'h08);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd & 8'hFD, 8'h00);
		for (i = 0; i < 8; i++) begin
			sleep_i <= tbl[i][12];
			bus(1'b1, 10'h10C, tbl[i][11:4]);
			repeat (3) @(posedge clk_i);
			chk({4'h0, pad_oe_o[0], pad_oe_o[0] & pad_o[0], pulldown_o[0], seq_owned_o[0]},
				{4'h0, tbl[i][3:0]});
			bus(1'b0, 10'h10C, 8'h00);
			chk(rd & 8'hFD, tbl[i][11:4]);
		end
		avs_byteenable <= 4'hE;
		bus(1'b1, 10'h10C, 8'h05);
		avs_byteenable <= 4'hF;
		bus(1'b0, 10'h10C, 8'h00);
		chk(rd & 8'hFD, 8'h00);
		bus(1'b0, 10'h3FC, 8'h00);
		chk({6'h00, rsp, rd[0]}, 8'h06);
		repeat (4000) @(posedge clk_i);
		bus(1'b1, 10'h110, 8'h02);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd, 8'h00);
		ext_v <= 2'b10;
		repeat (3700) @(posedge clk_i);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd, 8'h00);
		repeat (100) @(posedge clk_i);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd, 8'h02);
		bus(1'b1, 10'h110, 8'h10);
		ext_v <= 2'b00;
		repeat (6150) @(posedge clk_i);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd, 8'h12);
		repeat (150) @(posedge clk_i);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd, 8'h10);
		bus(1'b1, 10'h110, 8'h45);
		repeat (3) @(posedge clk_i);
		chk({4'h0, pad_oe_o[1], pad_o[1], pulldown_o[1], seq_owned_o[1]}, 8'h09);
		bus(1'b0, 10'h140, 8'h00);
		chk({rsp, rd[5:0]}, 8'h01);
		nrst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		bus(1'b0, 10'h10C, 8'h00);
		chk(rd & 8'hFD, 8'h08);
		bus(1'b0, 10'h110, 8'h00);
		chk(rd & 8'hFD, 8'h00);
		conclude;
	end
endmodule
